//--- core/shunt_format_pkg.sv
// Purpose: constants shared by the shunt format controller
// Assumes: 200 MHz system clock
// Notes:   packet match values and sequencer defaults
package shunt_format_pkg;
  localparam int unsigned CLK_HZ            = 200_000_000;
  localparam int unsigned TICK_SECONDS      = 1;
  localparam int unsigned TICK_CYCLES       = CLK_HZ * TICK_SECONDS;
  localparam int unsigned PC_TIMEOUT_S      = 12;
  localparam int unsigned MAX_DWELL_S       = 3600;
  localparam logic [15:0] FORMAT_OFF        = 16'h0000;
  localparam logic [15:0] FORMAT_A_RESET    = 16'h0004;
  localparam logic [15:0] FORMAT_B_RESET    = 16'h0008;
  localparam logic [15:0] FORMAT_POSITIVE   = 16'h0004;
  localparam logic [15:0] FORMAT_INVERSE    = 16'h0008;
  localparam logic [47:0] CMD_DST_MAC       = 48'h0100_5E00_00FA;
  localparam logic [31:0] CMD_DST_IP        = 32'hE000_00FA;
  localparam logic [15:0] CMD_SRC_PORT      = 16'h27EC;
  localparam logic [15:0] CMD_DST_PORT      = 16'h280A;
  localparam logic [31:0] HDR_VERSION       = 32'h1100_0000;
  localparam logic [31:0] HDR_STREAM_ID     = 32'h0000_0000;
  localparam logic [31:0] HDR_FLAGS         = 32'h0000_0000;
  localparam logic [15:0] EVENT_SHUNT       = 16'h0310;
  localparam logic [11:0] DWELL_RESET_A     = 12'h004;
  localparam logic [11:0] DWELL_RESET_B     = 12'h000;
  localparam logic [11:0] DWELL_RESET_INIT  = 12'h00A;
  localparam logic [11:0] DWELL_RESET_GAP   = 12'h000;
endpackage

//--- core/shunt_tick_gen.sv
// Purpose: one-second tick from the system clock
// Assumes: period set by parameter, shortened for simulation
// Notes:   tick is a one-cycle pulse
`timescale 1ns/1ps
module shunt_tick_gen #(
  parameter int unsigned PERIOD = 200_000_000
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic resetn_in,
  // tick
  output logic      tick_out
);
  logic [31:0] count;
  wire         wrap = (count == 32'(PERIOD - 1));

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count    <= 32'h0000_0000;
      tick_out <= 1'b0;
    end else begin
      count    <= wrap ? 32'h0000_0000 : count + 32'h0000_0001;
      tick_out <= wrap;
    end
  end
endmodule

//--- core/shunt_format_controller.sv
// Purpose: chooses the bridge shunt format from a power-up sequencer and network commands
// Assumes: received packet fields arrive already parsed, one strobe per packet
// Notes:   formats are 16-bit numbers; 4 positive, 8 inverse, 0 off
//
// What this block does
// - master sends packet only on value change
// - shunt packets use stream identifier zero
// - slave keeps last master format until next
// - sequencer output is the master shunt source
// - wait startup delay before first switch
// - first format programmable, default four
// - second format programmable, default eight
// - hold first format; zero skips it
// - hold second format; zero skips it
// - format zero gap between first and second
// - hold times accepted up to 3600 seconds
// - PC commands match multicast address and UDP ports; master packets do not
// - PC commands match multicast Ethernet destination address
// - match version, zero stream, zero flags
// - event 0x0310 upper, format lower half
// - shunting-enabled controller obeys PC command
// - PC format returns to zero after 12s
// - four positive, eight inverse, zero removes
// - master switches and sends next acquisition cycle
`timescale 1ns/1ps
module shunt_format_controller
  import shunt_format_pkg::*;
#(
  parameter int unsigned TICK_PERIOD = TICK_CYCLES,
  parameter int unsigned PC_TIMEOUT  = PC_TIMEOUT_S
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  // configuration
  input  wire logic        shunt_enable_in,
  input  wire logic        is_master_in,
  input  wire logic [15:0] format_a_in,
  input  wire logic [15:0] format_b_in,
  input  wire logic [11:0] dwell_a_in,
  input  wire logic [11:0] dwell_b_in,
  input  wire logic [11:0] dwell_init_in,
  input  wire logic [11:0] dwell_gap_in,
  // acquisition cycle strobe
  input  wire logic        acq_cycle_in,
  // parsed received packet
  input  wire logic        rx_valid_in,
  input  wire logic        rx_from_pc_in,
  input  wire logic [47:0] rx_dst_mac_in,
  input  wire logic [31:0] rx_dst_ip_in,
  input  wire logic [15:0] rx_src_port_in,
  input  wire logic [15:0] rx_dst_port_in,
  input  wire logic [31:0] rx_version_in,
  input  wire logic [31:0] rx_stream_id_in,
  input  wire logic [31:0] rx_flags_in,
  input  wire logic [31:0] rx_event_in,
  // packet send request to the network
  output logic             tx_send_out,
  output logic [31:0]      tx_stream_id_out,
  output logic [31:0]      tx_event_out,
  // applied format
  output logic [15:0]      format_out,
  output logic             shunt_positive_out,
  output logic             shunt_inverse_out,
  output logic             seq_active_out,
  output logic             pc_active_out
);

  ////////////////////////////////////////////////////////////////////////////
  // tick and small helpers

  logic tick;

  shunt_tick_gen #(
    .PERIOD (TICK_PERIOD)
  ) u_tick (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .tick_out  (tick)
  );

  // dwell values above an hour are clamped rather than rejected
  function automatic logic [11:0] clamp_dwell(input logic [11:0] v);
    clamp_dwell = (v > 12'(MAX_DWELL_S)) ? 12'(MAX_DWELL_S) : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // power-up sequencer

  typedef enum logic [2:0] {
    SEQ_INIT,
    SEQ_A,
    SEQ_GAP,
    SEQ_B,
    SEQ_IDLE
  } seq_state_t;

  seq_state_t  seq_state;
  seq_state_t  next_seq_state;
  logic [11:0] seq_count;
  logic [11:0] next_seq_count;
  logic [15:0] seq_format;
  logic [15:0] next_seq_format;
  // low for the first cycle after reset, when the startup dwell is loaded
  logic        init_loaded;

  wire [11:0] dw_a    = clamp_dwell(dwell_a_in);
  wire [11:0] dw_b    = clamp_dwell(dwell_b_in);
  wire [11:0] dw_init = clamp_dwell(dwell_init_in);
  wire [11:0] dw_gap  = clamp_dwell(dwell_gap_in);
  wire        expired = tick && (seq_count <= 12'h001);

  // chooses the next stage after each dwell, skipping empty ones
  always_comb begin
    next_seq_state  = seq_state;
    next_seq_count  = seq_count;
    next_seq_format = seq_format;
    if (tick && seq_count != 12'h000 && !expired) begin
      next_seq_count = seq_count - 12'h001;
    end
    case (seq_state)
      SEQ_INIT: begin
        if (!init_loaded) begin
          // async reset cannot load a port value, so the live dwell lands here
          next_seq_count = dw_init;
        end else if (dw_init == 12'h000 || expired) begin
          if (dw_a != 12'h000) begin
            next_seq_state  = SEQ_A;
            next_seq_count  = dw_a;
            next_seq_format = format_a_in;
          end else if (dw_b != 12'h000) begin
            next_seq_state  = SEQ_B;
            next_seq_count  = dw_b;
            next_seq_format = format_b_in;
          end else begin
            next_seq_state  = SEQ_IDLE;
            next_seq_format = FORMAT_OFF;
          end
        end
      end
      SEQ_A: begin
        if (expired) begin
          if (dw_gap != 12'h000) begin
            next_seq_state  = SEQ_GAP;
            next_seq_count  = dw_gap;
            next_seq_format = FORMAT_OFF;
          end else if (dw_b != 12'h000) begin
            next_seq_state  = SEQ_B;
            next_seq_count  = dw_b;
            next_seq_format = format_b_in;
          end else begin
            next_seq_state  = SEQ_IDLE;
            next_seq_format = FORMAT_OFF;
          end
        end
      end
      SEQ_GAP: begin
        if (expired) begin
          if (dw_b != 12'h000) begin
            next_seq_state  = SEQ_B;
            next_seq_count  = dw_b;
            next_seq_format = format_b_in;
          end else begin
            next_seq_state  = SEQ_IDLE;
            next_seq_format = FORMAT_OFF;
          end
        end
      end
      SEQ_B: begin
        if (expired) begin
          next_seq_state  = SEQ_IDLE;
          next_seq_format = FORMAT_OFF;
        end
      end
      default: begin
        next_seq_state  = SEQ_IDLE;
        next_seq_format = FORMAT_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seq_state  <= SEQ_INIT;
      seq_count  <= DWELL_RESET_INIT;
      seq_format <= FORMAT_OFF;
    end else begin
      seq_state  <= next_seq_state;
      seq_count  <= next_seq_count;
      seq_format <= next_seq_format;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master: send a packet when the sequencer output changes

  logic [15:0] last_sent;
  logic        change_pending;
  wire         source_changed = (seq_format != last_sent);

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      last_sent        <= FORMAT_OFF;
      change_pending   <= 1'b0;
      tx_send_out      <= 1'b0;
      tx_stream_id_out <= 32'h0000_0000;
      tx_event_out     <= 32'h0000_0000;
    end else begin
      tx_send_out <= 1'b0;
      if (is_master_in && shunt_enable_in && source_changed) begin
        change_pending <= 1'b1;
      end
      if (change_pending && acq_cycle_in) begin
        change_pending   <= 1'b0;
        last_sent        <= seq_format;
        tx_send_out      <= 1'b1;
        tx_stream_id_out <= HDR_STREAM_ID;
        tx_event_out     <= {EVENT_SHUNT, seq_format};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // packet decoder; trailing description text is not examined

  wire hdr_ok   = (rx_version_in == HDR_VERSION) && (rx_stream_id_in == HDR_STREAM_ID)
                  && (rx_flags_in == HDR_FLAGS);
  wire event_ok = (rx_event_in[31:16] == EVENT_SHUNT);
  wire pc_ok    = (rx_dst_mac_in == CMD_DST_MAC) && (rx_dst_ip_in == CMD_DST_IP)
                  && (rx_src_port_in == CMD_SRC_PORT)
                  && (rx_dst_port_in == CMD_DST_PORT);
  // anything failing the match leaves the format alone
  wire cmd_ok   = rx_valid_in && shunt_enable_in && hdr_ok && event_ok;
  wire pc_cmd   = cmd_ok && rx_from_pc_in && pc_ok;
  wire mst_cmd  = cmd_ok && !rx_from_pc_in && !is_master_in;

  ////////////////////////////////////////////////////////////////////////////
  // applied format and PC timeout

  logic [15:0] applied;
  logic [7:0]  pc_secs;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      applied       <= FORMAT_OFF;
      pc_secs       <= 8'h00;
      pc_active_out <= 1'b0;
    end else begin
      if (pc_cmd) begin
        applied       <= rx_event_in[15:0];
        pc_secs       <= 8'(PC_TIMEOUT);
        pc_active_out <= 1'b1;
      end else if (mst_cmd) begin
        applied       <= rx_event_in[15:0];
        pc_active_out <= 1'b0;
      end else if (is_master_in && tx_send_out) begin
        applied <= tx_event_out[15:0];
      end else if (pc_active_out && tick) begin
        if (pc_secs <= 8'h01) begin
          applied       <= FORMAT_OFF;
          pc_active_out <= 1'b0;
        end
        pc_secs <= pc_secs - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      format_out         <= FORMAT_OFF;
      shunt_positive_out <= 1'b0;
      shunt_inverse_out  <= 1'b0;
      init_loaded        <= 1'b0;
    end else begin
      format_out         <= applied;
      shunt_positive_out <= (applied == FORMAT_POSITIVE);
      shunt_inverse_out  <= (applied == FORMAT_INVERSE);
      init_loaded        <= 1'b1;
    end
  end

  assign seq_active_out = (seq_state != SEQ_IDLE);

endmodule

//--- test/shunt_format_controller_sva.sv
// Purpose: port checks for the shunt format controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   attached to every controller instance by bind
`timescale 1ns/1ps
module shunt_format_controller_sva
  import shunt_format_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        resetn_in,
  input wire logic        shunt_enable_in,
  input wire logic        is_master_in,
  input wire logic        acq_cycle_in,
  input wire logic        rx_valid_in,
  input wire logic        rx_from_pc_in,
  input wire logic [47:0] rx_dst_mac_in,
  input wire logic [31:0] rx_dst_ip_in,
  input wire logic [15:0] rx_src_port_in,
  input wire logic [15:0] rx_dst_port_in,
  input wire logic [31:0] rx_version_in,
  input wire logic [31:0] rx_stream_id_in,
  input wire logic [31:0] rx_flags_in,
  input wire logic [31:0] rx_event_in,
  input wire logic        tx_send_out,
  input wire logic [31:0] tx_stream_id_out,
  input wire logic [31:0] tx_event_out,
  input wire logic [15:0] format_out,
  input wire logic        shunt_positive_out,
  input wire logic        shunt_inverse_out,
  input wire logic        pc_active_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  wire pc_ok = rx_valid_in && rx_from_pc_in && shunt_enable_in && rx_dst_mac_in == CMD_DST_MAC
    && rx_dst_ip_in == CMD_DST_IP && rx_src_port_in == CMD_SRC_PORT
    && rx_dst_port_in == CMD_DST_PORT && rx_version_in == HDR_VERSION
    && rx_stream_id_in == HDR_STREAM_ID && rx_flags_in == HDR_FLAGS
    && rx_event_in[31:16] == EVENT_SHUNT;
  //////////////////////////////////////////////////////////////////////////////
  stream_zero_a: assert property (tx_send_out |-> tx_stream_id_out == 32'h0000_0000)
    else $error("shunt packet sent with nonzero stream id");
  event_code_a: assert property (tx_send_out |-> tx_event_out[31:16] == EVENT_SHUNT)
    else $error("shunt packet sent with wrong event code");
  send_master_a: assert property (tx_send_out |-> $past(is_master_in && shunt_enable_in))
    else $error("packet sent while not an enabled master");
  send_acq_a: assert property (tx_send_out |-> $past(acq_cycle_in) || $past(acq_cycle_in, 2))
    else $error("packet sent without an acquisition cycle");
  send_apply_a: assert property (tx_send_out |-> ##2 format_out == $past(tx_event_out[15:0], 2))
    else $error("master did not apply the format it sent");
  pc_apply_a: assert property (pc_ok |=> pc_active_out ##1 format_out == $past(rx_event_in[15:0], 2))
    else $error("matching command not applied two cycles later");
  pc_expire_a: assert property ($fell(pc_active_out) |-> ##[0:2] format_out == FORMAT_OFF)
    else $error("expired command did not return format to off");
  pos_map_a: assert property (format_out == FORMAT_POSITIVE |-> ##[0:1] shunt_positive_out)
    else $error("format four without positive shunt");
  inv_map_a: assert property (format_out == FORMAT_INVERSE |-> ##[0:1] shunt_inverse_out)
    else $error("format eight without inverse shunt");
endmodule
bind shunt_format_controller shunt_format_controller_sva chk (.*);

//--- test/shunt_net_model.sv
// Purpose: network side delivering parsed shunt command packets
// Assumes: fields change at the falling edge and stand one cycle
// Notes:   released fields turn inverted so stale data never matches
`timescale 1ns/1ps
module shunt_net_model
  import shunt_format_pkg::*;
(
  input  wire logic        mclk_in,
  output logic             valid_out,
  output logic             pc_out,
  output logic [47:0]      mac_out,
  output logic [31:0]      ip_out,
  output logic [15:0]      sport_out,
  output logic [15:0]      dport_out,
  output logic [31:0]      ver_out,
  output logic [31:0]      sid_out,
  output logic [31:0]      flags_out,
  output logic [31:0]      event_out
);
  initial {valid_out, pc_out, mac_out, ip_out, sport_out, dport_out} = '0;
  initial {ver_out, sid_out, flags_out, event_out} = '0;
  // bad picks one field to spoil by one bit, 0 sends a clean packet
  // any trailing description text stays behind the parser, never shown
  task automatic send(input logic pc, input logic [15:0] fmt, input int bad);
    @(negedge mclk_in);
    valid_out = 1'b1;
    pc_out    = pc;
    mac_out   = CMD_DST_MAC ^ 48'(bad == 1);
    ip_out    = CMD_DST_IP ^ 32'(bad == 2);
    sport_out = CMD_SRC_PORT ^ 16'(bad == 3);
    dport_out = CMD_DST_PORT ^ 16'(bad == 4);
    ver_out   = HDR_VERSION ^ 32'(bad == 5);
    sid_out   = HDR_STREAM_ID ^ 32'(bad == 6);
    flags_out = HDR_FLAGS ^ 32'(bad == 7);
    event_out = {EVENT_SHUNT ^ 16'(bad == 8), fmt};
    @(negedge mclk_in);
    valid_out = 1'b0;
    {mac_out, ip_out, sport_out, dport_out} = ~{mac_out, ip_out, sport_out, dport_out};
    {ver_out, sid_out, flags_out, event_out} = ~{ver_out, sid_out, flags_out, event_out};
  endtask
endmodule

//--- test/shunt_format_controller_test.sv
// Purpose: self-checking bench for the shunt format controller
// Assumes: tick shortened to TP cycles
// Notes:   queue model holds the formats the master must send
`timescale 1ns/1ps
module shunt_format_controller_test;
  import shunt_format_pkg::*;
  localparam int TP = 10;
  logic        mclk_in = 1'b0, resetn_in = 1'b0, acq_cycle_in = 1'b0;
  logic        shunt_enable_in = 1'b1, is_master_in = 1'b1;
  logic [15:0] format_a_in = 16'h0004, format_b_in = 16'h0008;
  logic [11:0] dwell_a_in = 12'h002, dwell_b_in = 12'h002;
  logic [11:0] dwell_init_in = 12'h002, dwell_gap_in = 12'h001;
  logic        rx_valid_in, rx_from_pc_in, tx_send_out, shunt_positive_out, shunt_inverse_out;
  logic        seq_active_out, pc_active_out;
  logic [47:0] rx_dst_mac_in;
  logic [31:0] rx_dst_ip_in, rx_version_in, rx_stream_id_in, rx_flags_in, rx_event_in;
  logic [31:0] tx_stream_id_out, tx_event_out;
  logic [15:0] rx_src_port_in, rx_dst_port_in, format_out;
  int          error_cnt = 0, n_compared = 0;
  logic [15:0] exp_q[$];
  always #2.5 mclk_in = ~mclk_in;
  shunt_format_controller #(.TICK_PERIOD(TP)) dut (.*);
  shunt_net_model net (.mclk_in, .valid_out(rx_valid_in), .pc_out(rx_from_pc_in),
    .mac_out(rx_dst_mac_in), .ip_out(rx_dst_ip_in), .sport_out(rx_src_port_in),
    .dport_out(rx_dst_port_in), .ver_out(rx_version_in), .sid_out(rx_stream_id_in),
    .flags_out(rx_flags_in), .event_out(rx_event_in));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    n_compared++;
    if (seen !== want) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset();
    resetn_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    resetn_in = 1'b1;
  endtask
  // acquisition cycles arrive at random so a send may wait a few cycles
  always @(negedge mclk_in) begin
    acq_cycle_in <= 1'($urandom_range(0, 1));
    if (tx_send_out === 1'b1)
      check(tx_event_out, {EVENT_SHUNT, exp_q.size() ? exp_q.pop_front() : 16'hffff}, "sent");
  end
  task automatic seq_run(input logic [11:0] a, input logic [11:0] g, input logic [11:0] b);
    int n;
    {dwell_a_in, dwell_gap_in, dwell_b_in} = {a, g, b};
    if (a != 0) exp_q.push_back(format_a_in);
    if (a != 0 && b != 0 && g != 0) exp_q.push_back(FORMAT_OFF);
    if (b != 0) exp_q.push_back(format_b_in);
    if (a != 0 || b != 0) exp_q.push_back(FORMAT_OFF);
    n = exp_q.size();
    do_reset();
    repeat (TP) @(negedge mclk_in);
    check(32'(exp_q.size()), 32'(n), "early switch");
    check(32'(seq_active_out), 32'(1), "seq running");
    repeat (12 * TP) @(negedge mclk_in);
    check(32'(exp_q.size()), 0, "sends left");
    check(format_out, FORMAT_OFF, "idle format");
    check(32'(seq_active_out), 0, "seq idle");
    $display("sequence test %0d %0d %0d done", a, g, b);
  endtask
  task automatic pc_run();
    logic [15:0] f;
    f = $urandom_range(0, 1) ? FORMAT_POSITIVE : FORMAT_INVERSE;
    {is_master_in, dwell_a_in, dwell_b_in} = '0;
    do_reset();
    net.send(1'b1, f, 0);
    repeat (2) @(negedge mclk_in);
    check(format_out, f, "pc format");
    check({shunt_positive_out, shunt_inverse_out}, {f == 4, f == 8}, "shunt");
    for (int i = 1; i <= 8; i++) net.send(1'b1, 16'h0001, i);
    repeat (2) @(negedge mclk_in);
    check(format_out, f, "bad packets");
    repeat (80) @(negedge mclk_in);
    check(format_out, f, "early expiry");
    repeat (25) @(negedge mclk_in);
    check({pc_active_out, format_out}, 0, "expiry");
    net.send(1'b0, f, 0);
    repeat (150) @(negedge mclk_in);
    check(format_out, f, "master hold");
    shunt_enable_in = 1'b0;
    net.send(1'b1, 16'h0001, 0);
    repeat (3) @(negedge mclk_in);
    check(format_out, f, "disabled");
    $display("network test done");
  endtask
  // four sequences of about 135 cycles plus some 300 for the network test
  initial begin
    #20_000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end
  initial begin
    void'($urandom(32'h0000_19ff));
    format_a_in = 16'($urandom_range(1, 15));
    format_b_in = format_a_in + 16'h0010;
    seq_run(12'h002, 12'h001, 12'h002);
    seq_run(12'h000, 12'h001, 12'h002);
    seq_run(12'h002, 12'h000, 12'h002);
    seq_run(12'h002, 12'h001, 12'h000);
    pc_run();
    give_verdict();
  end
endmodule
